// ---- inc/power_mgmt_pkg.sv ----
// types shared by the power management capability block
// assumes power_mgmt_regs.svh holds every number
package power_mgmt_pkg;

    // software register port, one request per cycle
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    // wake event inputs from the port logic
    typedef struct packed {
        logic own_wake;
        logic fwd_wake;
    } wake_in_t;

    // the whole state of the block, registered as one word
    typedef struct packed {
        logic [7:0]  next_ptr;
        logic        special_init;
        logic [2:0]  aux_code;
        logic [4:0]  wake_support;
        logic [1:0]  power_state_field;
        logic        keep_ctx;
        logic        wake_en;
        logic        wake_sts;
        logic [2:0]  irq_sts;
        logic [2:0]  irq_mask;
        logic [31:0] rdata;
        logic        irq;
        logic        wake_msg;
        logic        fwd_msg;
        logic        ctx_reset;
    } pm_state_t;

endpackage

// ---- inc/power_mgmt_regs.svh ----
// offsets, field positions, reset values of the power management capability
// assumes a 12-bit configuration byte address and 32-bit register words
`ifndef POWER_MGMT_REGS_SVH
`define POWER_MGMT_REGS_SVH

// register byte addresses
`define PM_CAP_OFF        12'h0c0
`define PM_CSR_OFF        12'h0c4
`define PM_IRQ_STS_OFF    12'h0c8
`define PM_IRQ_MASK_OFF   12'h0cc

// capabilities word fields
`define PM_CAPABILITY_IDENTIFIER_LSB      0
`define PM_NXT_LSB        8
`define PM_REV_LSB        16
`define PM_CLKREQ_BIT     19
`define PM_SPECIAL_BIT    21
`define PM_AUX_LSB        22
`define PM_D1_BIT         25
`define PM_D2_BIT         26
`define PM_WSUP_LSB       27

// control and status word fields
`define PM_POWER_STATE_FIELD_LSB     0
`define PM_KEEPCTX_BIT    3
`define PM_WEN_BIT        8
`define PM_WSTS_BIT       15

// fixed values and reset values
`define PM_CAPABILITY_IDENTIFIER_VAL      8'h01
`define PM_NXT_RST        8'hd0
`define PM_REV_VAL        3'h3
`define PM_SPECIAL_RST    1'h0
`define PM_AUX_RST        3'h7
`define PM_WSUP_RST       5'h19
`define PM_POWER_STATE_FIELD_D0      2'h0
`define PM_POWER_STATE_FIELD_D3HOT   2'h3
`define PM_KEEPCTX_RST    1'h1
`define PM_WEN_RST        1'h0
`define PM_WSTS_RST       1'h0

// interrupt status bits
`define PM_IRQ_WAKE_BIT   0
`define PM_IRQ_POWER_STATE_FIELD_BIT 1
`define PM_IRQ_CTXRST_BIT 2
`define PM_IRQ_W          3

`endif

// ---- src/power_mgmt_capability_regs.sv ----
// power management capability registers of one switch port, with
// wake event handling and an interrupt over three block events
// assumes a plain register port in the sys_clk domain, read data a cycle
// later, and hot_reset, cfg_unlock and wake inputs synchronous to sys_clk
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`include "power_mgmt_regs.svh"

module power_mgmt_capability_regs (
    input  wire logic                       sys_clk,
    input  wire logic                       rst,
    input  wire logic                       hot_reset,
    input  wire logic                       cfg_unlock,
    input  wire power_mgmt_pkg::reg_req_t   req,
    input  wire power_mgmt_pkg::wake_in_t   wake_in,
    output logic [31:0]                     rdata,
    output logic                            irq,
    output logic                            wake_msg_req,
    output logic                            fwd_msg_req,
    output logic                            ctx_reset_req,
    output logic [1:0]                      power_state
);

    power_mgmt_pkg::pm_state_t state;
    power_mgmt_pkg::pm_state_t next_state;

    // address match, used for every register in both directions
    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] off);
        hit = (a == off);
    endfunction

    // assembled capabilities word; unlisted bits stay zero
    function automatic logic [31:0] cap_word(
            input power_mgmt_pkg::pm_state_t s);
        logic [31:0] w;
        w = 32'h0;
        w[`PM_CAPABILITY_IDENTIFIER_LSB +: 8] = `PM_CAPABILITY_IDENTIFIER_VAL;
        w[`PM_NXT_LSB +: 8]   = s.next_ptr;
        w[`PM_REV_LSB +: 3]   = `PM_REV_VAL;
        // clock and intermediate-state bits held zero
        w[`PM_CLKREQ_BIT]     = 1'b0;
        w[`PM_D1_BIT]         = 1'b0;
        w[`PM_D2_BIT]         = 1'b0;
        w[`PM_SPECIAL_BIT]    = s.special_init;
        w[`PM_AUX_LSB +: 3]   = s.aux_code;
        w[`PM_WSUP_LSB +: 5]  = s.wake_support;
        cap_word = w;
    endfunction

    // assembled control and status word
    function automatic logic [31:0] csr_word(
            input power_mgmt_pkg::pm_state_t s);
        logic [31:0] w;
        // data and bus power fields stay zero
        w = 32'h0;
        w[`PM_POWER_STATE_FIELD_LSB +: 2] = s.power_state_field;
        w[`PM_KEEPCTX_BIT]     = s.keep_ctx;
        w[`PM_WEN_BIT]         = s.wake_en;
        w[`PM_WSTS_BIT]        = s.wake_sts;
        csr_word = w;
    endfunction

    // next state: writes, events, hot reset and read data
    always_comb begin
        logic                    wr_cap;
        logic                    wr_csr;
        logic [1:0]              new_ps;
        logic [`PM_IRQ_W-1:0]    ev;
        wr_cap = req.wr && hit(req.addr, `PM_CAP_OFF);
        wr_csr = req.wr && hit(req.addr, `PM_CSR_OFF);
        new_ps = req.wdata[`PM_POWER_STATE_FIELD_LSB +: 2];
        ev     = '0;
        next_state = state;

        // lockable fields take register writes only while unlocked
        if (wr_cap && cfg_unlock) begin
            next_state.next_ptr     = req.wdata[`PM_NXT_LSB +: 8];
            next_state.special_init = req.wdata[`PM_SPECIAL_BIT];
        end
        // sticky capability fields are plain writable
        if (wr_cap) begin
            next_state.aux_code     = req.wdata[`PM_AUX_LSB +: 3];
            next_state.wake_support = req.wdata[`PM_WSUP_LSB +: 5];
        end

        next_state.ctx_reset = 1'b0;
        if (wr_csr) begin
            // reserved state codes leave the held state alone
            if (new_ps == `PM_POWER_STATE_FIELD_D0 || new_ps == `PM_POWER_STATE_FIELD_D3HOT) begin
                next_state.power_state_field = new_ps;
                if (new_ps != state.power_state_field) begin
                    ev[`PM_IRQ_POWER_STATE_FIELD_BIT] = 1'b1;
                end
                // context is dropped leaving D3hot unless kept
                if (state.power_state_field == `PM_POWER_STATE_FIELD_D3HOT &&
                    new_ps == `PM_POWER_STATE_FIELD_D0 && !state.keep_ctx) begin
                    next_state.ctx_reset = 1'b1;
                    ev[`PM_IRQ_CTXRST_BIT] = 1'b1;
                end
            end
            if (cfg_unlock) begin
                next_state.keep_ctx = req.wdata[`PM_KEEPCTX_BIT];
            end
            next_state.wake_en = req.wdata[`PM_WEN_BIT];
            if (req.wdata[`PM_WSTS_BIT]) begin
                next_state.wake_sts = 1'b0;
            end
        end

        // own wake sets status regardless of enable; set beats clear
        // forwarded wake is not considered here
        if (wake_in.own_wake) begin
            next_state.wake_sts = 1'b1;
            ev[`PM_IRQ_WAKE_BIT] = 1'b1;
        end
        next_state.wake_msg = wake_in.own_wake && state.wake_en;
        // forwarding is the bridge's job and needs no local enable
        next_state.fwd_msg  = wake_in.fwd_wake;

        // interrupt status: write one clears, a new event wins
        if (req.wr && hit(req.addr, `PM_IRQ_STS_OFF)) begin
            next_state.irq_sts = state.irq_sts &
                                 ~req.wdata[`PM_IRQ_W-1:0];
        end
        next_state.irq_sts = next_state.irq_sts | ev;
        if (req.wr && hit(req.addr, `PM_IRQ_MASK_OFF)) begin
            next_state.irq_mask = req.wdata[`PM_IRQ_W-1:0];
        end
        next_state.irq = |(next_state.irq_sts & next_state.irq_mask);

        // hot reset restores non-sticky fields only
        // wake enable, status and sticky capability fields untouched
        if (hot_reset) begin
            next_state.next_ptr     = `PM_NXT_RST;
            next_state.special_init = `PM_SPECIAL_RST;
            next_state.power_state_field       = `PM_POWER_STATE_FIELD_D0;
            next_state.keep_ctx     = `PM_KEEPCTX_RST;
            next_state.ctx_reset    = 1'b0;
        end

        // unmapped addresses and reserved bits read zero
        next_state.rdata = 32'h0;
        if (req.rd) begin
            if (hit(req.addr, `PM_CAP_OFF)) begin
                next_state.rdata = cap_word(state);
            end else if (hit(req.addr, `PM_CSR_OFF)) begin
                next_state.rdata = csr_word(state);
            end else if (hit(req.addr, `PM_IRQ_STS_OFF)) begin
                next_state.rdata = {29'h0, state.irq_sts};
            end else if (hit(req.addr, `PM_IRQ_MASK_OFF)) begin
                next_state.rdata = {29'h0, state.irq_mask};
            end
        end
    end

    // state register; fundamental reset loads every field
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state              <= '0;
            state.next_ptr     <= `PM_NXT_RST;
            state.special_init <= `PM_SPECIAL_RST;
            state.aux_code     <= `PM_AUX_RST;
            state.wake_support <= `PM_WSUP_RST;
            state.power_state_field       <= `PM_POWER_STATE_FIELD_D0;
            state.keep_ctx     <= `PM_KEEPCTX_RST;
            // of the resets, only fundamental reset clears the enable
            state.wake_en      <= `PM_WEN_RST;
            state.wake_sts     <= `PM_WSTS_RST;
        end else begin
            state <= next_state;
        end
    end

    // outputs straight from the state flops
    assign rdata         = state.rdata;
    assign irq           = state.irq;
    assign wake_msg_req  = state.wake_msg;
    assign fwd_msg_req   = state.fwd_msg;
    assign ctx_reset_req = state.ctx_reset;
    assign power_state   = state.power_state_field;

endmodule

// ---- verif/power_mgmt_capability_regs_chk.sv ----
// port assertions for the power management capability registers
// assumes binding onto the block; sees only its ports
`timescale 1ns/1ps
module power_mgmt_capability_regs_chk (
    input wire logic                     sys_clk,
    input wire logic                     rst,
    input wire logic                     hot_reset,
    input wire logic                     cfg_unlock,
    input wire power_mgmt_pkg::reg_req_t req,
    input wire power_mgmt_pkg::wake_in_t wake_in,
    input wire logic [31:0]              rdata,
    input wire logic                     irq,
    input wire logic                     wake_msg_req,
    input wire logic                     fwd_msg_req,
    input wire logic                     ctx_reset_req,
    input wire logic [1:0]               power_state
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // read requests of the two words, answered one cycle later
    sequence s_rd_cap; req.rd && req.addr == 12'h0c0; endsequence
    sequence s_rd_csr;
        req.rd && req.addr == 12'h0c4 && !hot_reset;
    endsequence
    property p_cap_fixed; s_rd_cap |=> rdata[7:0] == 8'h01
        && rdata[20:16] == 5'h03 && rdata[26:25] == 2'h0; endproperty
    property p_csr_zero; s_rd_csr |=> (rdata & 32'hffff7ef4) == 32'h0;
    endproperty
    property p_csr_state; s_rd_csr |=> rdata[1:0] == $past(power_state);
    endproperty
    property p_idle; !req.rd |=> rdata == 32'h0; endproperty
    property p_unmapped; req.rd && req.addr[11:4] != 8'h0c |=> rdata == 0;
    endproperty
    property p_legal; power_state != 2'h1 && power_state != 2'h2; endproperty
    property p_hot; hot_reset |=> power_state == 2'h0 && !ctx_reset_req;
    endproperty
    property p_ctx; ctx_reset_req |-> $past(power_state) == 2'h3; endproperty
    property p_fwd; fwd_msg_req == $past(wake_in.fwd_wake); endproperty
    property p_wake; !wake_in.own_wake |=> !wake_msg_req; endproperty
    a_cap_fixed: assert property (p_cap_fixed) else $error("cap fixed");
    a_csr_zero: assert property (p_csr_zero) else $error("csr zero");
    a_csr_state: assert property (p_csr_state) else $error("state");
    a_idle: assert property (p_idle) else $error("idle rdata");
    a_unmapped: assert property (p_unmapped) else $error("unmapped");
    a_legal: assert property (p_legal) else $error("bad state");
    a_hot: assert property (p_hot) else $error("hot reset");
    a_ctx: assert property (p_ctx) else $error("ctx reset");
    a_fwd: assert property (p_fwd) else $error("forward");
    a_wake: assert property (p_wake) else $error("wake msg");
endmodule

bind power_mgmt_capability_regs power_mgmt_capability_regs_chk u_chk (
    .sys_clk, .rst, .hot_reset, .cfg_unlock, .req, .wake_in, .rdata, .irq,
    .wake_msg_req, .fwd_msg_req, .ctx_reset_req, .power_state);

// ---- verif/power_mgmt_capability_regs_tb_top.sv ----
// self-checking bench for the power management capability registers
// assumes the checker file binds itself onto the block
`timescale 1ns/1ps
module power_mgmt_capability_regs_tb_top;
    logic sys_clk = 0, rst = 1, hot_reset = 0, cfg_unlock = 0, rd_d = 0;
    power_mgmt_pkg::reg_req_t req = '0;
    power_mgmt_pkg::wake_in_t wake_in = '0;
    logic [31:0] rdata, rnd = 32'h94a7, exp_q[$];
    logic irq, wake_msg_req, fwd_msg_req, ctx_reset_req;
    logic [1:0] power_state;
    int error_cnt = 0, samples_checked = 0, cycles = 0;
    power_mgmt_capability_regs u_power_mgmt_capability_regs (.sys_clk,
        .rst, .hot_reset, .cfg_unlock, .req, .wake_in, .rdata, .irq,
        .wake_msg_req, .fwd_msg_req, .ctx_reset_req, .power_state);
    initial forever #10 sys_clk = ~sys_clk;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one bus cycle; on a read d is the expected word, noted for the monitor
    task automatic bus(input logic [11:0] a, input logic [31:0] d, logic r);
        @(posedge sys_clk);
        req <= '{a, d, !r, r};
        if (r) exp_q.push_back(d);
    endtask
    // release the request, hot reset and wake inputs, then look just after the edge
    task automatic idle1();
        @(posedge sys_clk);
        req <= '0;
        hot_reset <= 0;
        wake_in <= '0;
        #1;
    endtask
    task automatic step(input logic h, input logic [1:0] w);
        @(posedge sys_clk);
        req <= '0;
        hot_reset <= h;
        wake_in <= w;
        idle1();
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // read data stand only in the cycle after the strobe
    always @(posedge sys_clk) begin
        rd_d <= req.rd;
        if (rd_d) chk(rdata, exp_q.pop_front());
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            give_verdict();
        end
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 0;
        bus(12'h0c0, 32'hc9c3d001, 1);
        bus(12'h0c4, 32'h00000008, 1);
        rnd = xs(rnd);
        // locked: only the aux field takes the random code
        bus(12'h0c0, rnd & 32'h07ffffff | 32'hc8000000, 0);
        bus(12'h0c0, 32'hc803d001 | rnd & 32'h01c00000, 1);
        cfg_unlock <= 1;
        bus(12'h0c0, 32'hce3fab00, 0);
        bus(12'h0c0, 32'hc823ab01, 1);
        step(1, 2'h0);
        bus(12'h0c0, 32'hc803d001, 1);
        bus(12'h0cc, 32'h7, 0);
        bus(12'h0c4, 32'h103, 0);
        idle1();
        idle1();
        chk(irq, 1);
        bus(12'h0c8, 32'h2, 1);
        bus(12'h0c4, 32'h101, 0);
        bus(12'h0c4, 32'h103, 1);
        bus(12'h0c4, 32'h100, 0);
        idle1();
        chk(ctx_reset_req, 1);
        bus(12'h0c8, 32'h7, 0);
        step(1, 2'h0);
        bus(12'h0c4, 32'h108, 1);
        bus(12'h0c8, 32'h0, 1);
        step(0, 2'h2);
        chk(wake_msg_req, 1);
        step(0, 2'h1);
        chk(fwd_msg_req, 1);
        chk(irq, 1);
        bus(12'h0c4, 32'h8108, 1);
        bus(12'h0c4, 32'h8008, 0);
        bus(12'h0c4, 32'h8, 1);
        step(0, 2'h2);
        chk(wake_msg_req, 0);
        bus(12'h0c4, 32'h8008, 1);
        bus(12'h0cc, 32'h0, 0);
        idle1();
        idle1();
        chk(irq, 0);
        rnd = xs(rnd);
        bus({4'h1, rnd[7:2], 2'h0}, 32'h0, 1);
        step(0, 2'h0);
        // fundamental reset is the only one that clears the wake enable
        rst <= 1;
        repeat (2) @(posedge sys_clk);
        rst <= 0;
        bus(12'h0c4, 32'h8, 1);
        step(0, 2'h0);
        give_verdict();
    end
endmodule
